//--- rtl/dpllmt_pkg.sv
package dpllmt_pkg;
    // ************************************************
    // Widths and timing
    // ************************************************
    localparam int TS_W = 24;
    localparam int WORD_W = 49;
    localparam int CNT_W = 24;
    localparam int MLT_W = 10;
    localparam int PTR_W = 7;
    localparam int NCH = 6;
    localparam int LEFT_W = 11;
    localparam int CLK_HZ = 20_000_000;
    localparam logic [23:0] MAX_INC = 24'hFF_FFFF;
    // ************************************************
    // Capture word layout
    // ************************************************
    localparam int WRD_TS_LSB = 0;
    localparam int WRD_CNT_LSB = 24;
    localparam int WRD_LVL = 48;
    // ************************************************
    // Controller register map (byte offsets)
    // ************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TICKS = 8'h04;
    localparam logic [7:0] OFF_SYNC = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_PROF = 8'h10;
    localparam logic [7:0] OFF_PLEN = 8'h14;
    localparam logic [7:0] OFF_TIME = 8'h18;
    localparam logic [7:0] OFF_ANGLE = 8'h1C;
    localparam logic [7:0] OFF_ACT = 8'h20;
    localparam logic [7:0] OFF_ATIME = 8'h24;
    localparam logic [7:0] OFF_AANG = 8'h28;
    localparam logic [7:0] OFF_TCNT = 8'h2C;
    localparam int CTRL_EN = 0;
    localparam int CTRL_DIR = 1;
    localparam int CTRL_SEL_LSB = 4;
    localparam int PROF_ADR_LSB = 8;
    localparam int ACT_ID_LSB = 8;
    localparam int ST_LOCK = 0;
    localparam int ST_SYNC_OK = 1;
    localparam int ST_SYNC_NAK = 2;
    localparam int ST_ACT = 3;
    localparam logic [6:0] PLEN_RST = 7'h74;
    // ************************************************
    // Core lock states
    // ************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SEARCH = 4'b0010,
        ST_SYNCED = 4'b0100,
        ST_LOCKED = 4'b1000
    } dpllmt_state_t;
endpackage

//--- rtl/dpllmt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dpllmt_if;
    logic [5:0] cap_valid;
    logic [5:0][48:0] cap_word;
    logic enable;
    logic dir;
    logic [2:0] sec_sel;
    logic [9:0] ticks_m1;
    logic [6:0] prof_len;
    logic prof_we;
    logic [6:0] prof_addr;
    logic prof_gap;
    logic sync_req;
    logic [6:0] sync_ptr;
    logic act_req;
    logic [1:0] act_id;
    logic [6:0] act_teeth;
    logic [23:0] ts0;
    logic [23:0] ts1;
    logic [3:0] micro_tick;
    logic lock;
    logic sync_ack;
    logic sync_nak;
    logic act_ack;
    logic [23:0] act_time;
    logic [23:0] act_angle;
    modport dev (
        input cap_valid, cap_word, enable, dir, sec_sel, ticks_m1,
        input prof_len, prof_we, prof_addr, prof_gap, sync_req,
        input sync_ptr, act_req, act_id, act_teeth,
        output ts0, ts1, micro_tick, lock, sync_ack, sync_nak,
        output act_ack, act_time, act_angle
    );
    modport ctl (
        output cap_valid, cap_word, enable, dir, sec_sel, ticks_m1,
        output prof_len, prof_we, prof_addr, prof_gap, sync_req,
        output sync_ptr, act_req, act_id, act_teeth,
        input ts0, ts1, micro_tick, lock, sync_ack, sync_nak,
        input act_ack, act_time, act_angle
    );
endinterface
`default_nettype wire

//--- rtl/dpllmt_core.sv
`timescale 1ns/10ps
`default_nettype none
module dpllmt_core #(
    parameter int PROF_DEPTH = 128,
    parameter int ACT_SLOTS = 4
) (
    dpllmt_if.dev link,
    input wire logic mclk,
    input wire logic reset,
    output logic first_lock_flag,
    output logic [3:0] micro_tick
);
    // ************************************************
    // Types and state
    // ************************************************
    typedef struct packed {
        dpllmt_pkg::dpllmt_state_t st;
        logic [23:0] tb0;
        logic [23:0] tb1;
        logic [23:0] last_ts;
        logic [23:0] period;
        logic have_edge;
        logic last_gap;
        logic [6:0] ptr;
        logic [1:0] gaps;
        logic [23:0] acc1;
        logic [23:0] acc2;
        logic [10:0] left1;
        logic [10:0] left2;
        logic [10:0] miss1;
        logic [10:0] miss2;
        logic [23:0] sec_ts;
        logic sec_have;
        logic [3:0] tick;
        logic sync_ack;
        logic sync_nak;
        logic act_ack;
        logic [1:0] act_id;
    } dpllmt_core_t;

    dpllmt_core_t r;
    dpllmt_core_t n;

    // Memories
    logic prof_mem [PROF_DEPTH];
    logic [23:0] param_mem [3];
    logic [47:0] act_mem [ACT_SLOTS];

    if (PROF_DEPTH < 2 || PROF_DEPTH > 128 || ACT_SLOTS != 4) begin : g_chk
        $error("dpllmt_core: unsupported memory size");
    end

    // ************************************************
    // Arithmetic helpers
    // ************************************************
    // Increment = (ticks per edge << 24) / period
    function automatic logic [23:0] calc_inc(logic [9:0] m1,
                                             logic [23:0] per);
        logic [34:0] num;
        logic [34:0] q;
        num = {({1'b0, m1} + 11'h001), 24'h00_0000};
        if (per == 24'h00_0000) begin
            q = {11'h000, dpllmt_pkg::MAX_INC};
        end else begin
            q = num / {11'h000, per};
        end
        if (q > {11'h000, dpllmt_pkg::MAX_INC}) begin
            calc_inc = dpllmt_pkg::MAX_INC;
        end else begin
            calc_inc = q[23:0];
        end
    endfunction

    // One accumulator step: {tick, left, acc}
    function automatic logic [35:0] mt_step(logic [23:0] acc,
                                            logic [23:0] inc,
                                            logic [10:0] left);
        logic [24:0] sum;
        sum = {1'b0, acc} + {1'b0, inc};
        if (left != 11'h000) begin
            mt_step = {sum[24], left - {10'h000, sum[24]}, sum[23:0]};
        end else begin
            mt_step = {1'b0, left, acc};
        end
    endfunction

    // ************************************************
    // Next state
    // ************************************************
    logic [35:0] s1;
    logic [35:0] s2;
    logic [48:0] pw;
    logic [48:0] sw;
    logic sv;
    logic [23:0] per;
    logic [23:0] per2;
    logic gap;
    logic [6:0] nptr;
    logic [10:0] tpe;
    logic pinc_we;
    logic sinc_we;
    logic [23:0] delta;

    always_comb begin
        n = r;
        pw = link.cap_word[0];
        sv = 1'b0;
        sw = '0;
        if (link.sec_sel >= 3'h1 && link.sec_sel <= 3'h5) begin
            sv = link.cap_valid[link.sec_sel];
            sw = link.cap_word[link.sec_sel];
        end
        per = pw[23:0] - r.last_ts;
        per2 = sw[23:0] - r.sec_ts;
        gap = (r.period != 24'h00_0000) &&
              ({1'b0, per} > {1'b0, r.period} + {2'b00, r.period[23:1]});
        nptr = (r.ptr + 7'h01 >= link.prof_len) ? 7'h00 : r.ptr + 7'h01;
        tpe = {1'b0, link.ticks_m1} + 11'h001;
        pinc_we = 1'b0;
        sinc_we = 1'b0;
        s1 = mt_step(r.acc1, param_mem[0], r.left1);
        s2 = mt_step(r.acc2, param_mem[1], r.left2);
        n.tb0 = r.tb0 + 24'h00_0001;
        n.tick = 4'h0;
        n.sync_ack = 1'b0;
        n.sync_nak = 1'b0;
        n.act_ack = 1'b0;
        if (!link.enable) begin
            n.st = dpllmt_pkg::ST_IDLE;
            n.have_edge = 1'b0;
            n.sec_have = 1'b0;
            n.left1 = 11'h000;
            n.left2 = 11'h000;
            n.miss1 = 11'h000;
            n.miss2 = 11'h000;
            n.last_gap = 1'b0;
        end else begin
            if (r.st == dpllmt_pkg::ST_IDLE) begin
                n.st = dpllmt_pkg::ST_SEARCH;
            end
            // Four lines: regular and catch-up per generator
            n.acc1 = s1[23:0];
            n.left1 = s1[34:24];
            n.tick[0] = s1[35];
            n.acc2 = s2[23:0];
            n.left2 = s2[34:24];
            n.tick[2] = s2[35];
            if (r.miss1 != 11'h000) begin
                n.tick[1] = 1'b1;
                n.miss1 = r.miss1 - 11'h001;
            end
            if (r.miss2 != 11'h000) begin
                n.tick[3] = 1'b1;
                n.miss2 = r.miss2 - 11'h001;
            end
            if (link.cap_valid[0]) begin
                n.last_ts = pw[23:0];
                n.have_edge = 1'b1;
                if (r.have_edge) begin
                    // Unissued ticks of the last edge are caught up
                    n.miss1 = n.miss1 + s1[34:24];
                    n.left1 = tpe;
                    n.period = per;
                    n.last_gap = gap;
                    n.ptr = nptr;
                    pinc_we = 1'b1;
                    if (r.st == dpllmt_pkg::ST_SYNCED ||
                        r.st == dpllmt_pkg::ST_LOCKED) begin
                        if (gap != prof_mem[nptr]) begin
                            n.st = dpllmt_pkg::ST_SEARCH;
                        end else if (gap) begin
                            n.gaps = (r.gaps == 2'h3) ? r.gaps
                                                      : r.gaps + 2'h1;
                            if (r.gaps == 2'h1) begin
                                n.st = dpllmt_pkg::ST_LOCKED;
                            end
                        end
                    end
                end
            end
            if (sv) begin
                n.sec_ts = sw[23:0];
                n.sec_have = 1'b1;
                if (r.sec_have) begin
                    n.miss2 = n.miss2 + s2[34:24];
                    n.left2 = tpe;
                    sinc_we = 1'b1;
                end
            end
            // Pattern check guards against syncing mid-tooth
            if (link.sync_req) begin
                if (r.last_gap && prof_mem[link.sync_ptr]) begin
                    n.ptr = link.sync_ptr;
                    n.st = dpllmt_pkg::ST_SYNCED;
                    n.gaps = 2'h0;
                    n.sync_ack = 1'b1;
                end else begin
                    n.sync_nak = 1'b1;
                end
            end
        end
        // Angle follows the first micro tick lines
        delta = {22'h00_0000, ({1'b0, n.tick[0]} + {1'b0, n.tick[1]})};
        n.tb1 = link.dir ? r.tb1 - delta : r.tb1 + delta;
        if (link.act_req) begin
            n.act_ack = 1'b1;
            n.act_id = link.act_id;
        end
    end

    // ************************************************
    // Registers and memories
    // ************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            r <= '0;
            r.st <= dpllmt_pkg::ST_IDLE;
        end else begin
            r <= n;
        end
    end

    always_ff @(posedge mclk) begin
        if (link.prof_we) begin
            prof_mem[link.prof_addr] <= link.prof_gap;
        end
        if (pinc_we) begin
            param_mem[0] <= calc_inc(link.ticks_m1, per);
        end
        if (sinc_we) begin
            param_mem[1] <= calc_inc(link.ticks_m1, per2);
            param_mem[2] <= per2;
        end
        if (link.act_req) begin
            act_mem[link.act_id] <= {
                r.tb1 + 24'(link.act_teeth * tpe),
                r.last_ts + 24'(r.period * link.act_teeth)};
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign link.ts0 = r.tb0;
    assign link.ts1 = r.tb1;
    assign link.micro_tick = r.tick;
    assign micro_tick = r.tick;
    assign link.lock = (r.st == dpllmt_pkg::ST_LOCKED);
    assign first_lock_flag = (r.st == dpllmt_pkg::ST_LOCKED);
    assign link.sync_ack = r.sync_ack;
    assign link.sync_nak = r.sync_nak;
    assign link.act_ack = r.act_ack;
    assign link.act_time = act_mem[r.act_id][23:0];
    assign link.act_angle = act_mem[r.act_id][47:24];
endmodule // dpllmt_core
`default_nettype wire

//--- rtl/dpllmt_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module dpllmt_ctrl (
    dpllmt_if.ctl link,
    input wire logic mclk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [5:0] cap_pin
);
    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic [5:0][23:0] cnt;
        logic [5:0][48:0] word;
        logic [5:0] valid;
        logic [31:0] ctrl;
        logic [31:0] ticks;
        logic [31:0] plen;
        logic [3:1] sticky;
        logic sync_req;
        logic [6:0] sync_ptr;
        logic prof_we;
        logic [6:0] prof_addr;
        logic prof_gap;
        logic act_req;
        logic [1:0] act_id;
        logic [6:0] act_teeth;
        logic [23:0] tcnt;
        logic ack;
        logic [31:0] dat;
    } dpllmt_ctrl_t;

    dpllmt_ctrl_t r;
    dpllmt_ctrl_t n;
    logic req;
    logic [31:0] wd;

    // Byte-lane merge of a write into a register
    function automatic logic [31:0] wmerge(logic [31:0] old,
                                           logic [31:0] d,
                                           logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            wmerge[b*8 +: 8] = sel[b] ? d[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    always_comb begin
        n = r;
        req = wb_cyc_i && wb_stb_i && !r.ack;
        wd = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);
        // ************************************************
        // Capture channels
        // ************************************************
        n.s1 = cap_pin;
        n.s2 = r.s1;
        n.s3 = r.s2;
        for (int i = 0; i < 6; i++) begin
            n.valid[i] = 1'b0;
            if (r.s2[i] != r.s3[i]) begin
                n.cnt[i] = r.cnt[i] + 24'h00_0001;
                n.word[i] = {r.s2[i], n.cnt[i], link.ts0};
                n.valid[i] = 1'b1;
            end
        end
        // Both lines may pulse in one cycle, so each is counted
        n.tcnt = r.tcnt + {23'h00_0000, link.micro_tick[0]}
                        + {23'h00_0000, link.micro_tick[1]};
        // ************************************************
        // Wishbone slave, answers one cycle after request
        // ************************************************
        n.sync_req = 1'b0;
        n.prof_we = 1'b0;
        n.act_req = 1'b0;
        // Hardware set wins over software clear
        n.sticky = r.sticky | {link.act_ack, link.sync_nak, link.sync_ack};
        n.ack = req;
        n.dat = 32'h0000_0000;
        if (req && wb_we_i) begin
            case (wb_adr_i)
                dpllmt_pkg::OFF_CTRL: begin
                    n.ctrl = wmerge(r.ctrl, wb_dat_i, wb_sel_i);
                end
                dpllmt_pkg::OFF_TICKS: begin
                    n.ticks = wmerge(r.ticks, wb_dat_i, wb_sel_i);
                end
                dpllmt_pkg::OFF_PLEN: begin
                    n.plen = wmerge(r.plen, wb_dat_i, wb_sel_i);
                end
                dpllmt_pkg::OFF_SYNC: begin
                    n.sync_req = 1'b1;
                    n.sync_ptr = wd[6:0];
                end
                dpllmt_pkg::OFF_STATUS: begin
                    n.sticky = (r.sticky & ~wd[3:1]) |
                        {link.act_ack, link.sync_nak, link.sync_ack};
                end
                dpllmt_pkg::OFF_PROF: begin
                    n.prof_we = 1'b1;
                    n.prof_addr = wd[dpllmt_pkg::PROF_ADR_LSB +: 7];
                    n.prof_gap = wd[0];
                end
                dpllmt_pkg::OFF_ACT: begin
                    n.act_req = 1'b1;
                    n.act_teeth = wd[6:0];
                    n.act_id = wd[dpllmt_pkg::ACT_ID_LSB +: 2];
                end
                default: begin
                end
            endcase
        end else if (req) begin
            case (wb_adr_i)
                dpllmt_pkg::OFF_CTRL: n.dat = r.ctrl;
                dpllmt_pkg::OFF_TICKS: n.dat = r.ticks;
                dpllmt_pkg::OFF_PLEN: n.dat = r.plen;
                dpllmt_pkg::OFF_STATUS: n.dat = {28'h000_0000, r.sticky,
                                                 link.lock};
                dpllmt_pkg::OFF_TIME: n.dat = {8'h00, link.ts0};
                dpllmt_pkg::OFF_ANGLE: n.dat = {8'h00, link.ts1};
                dpllmt_pkg::OFF_ATIME: n.dat = {8'h00, link.act_time};
                dpllmt_pkg::OFF_AANG: n.dat = {8'h00, link.act_angle};
                dpllmt_pkg::OFF_TCNT: n.dat = {8'h00, r.tcnt};
                default: n.dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            r <= '0;
            r.plen <= {25'h000_0000, dpllmt_pkg::PLEN_RST};
        end else begin
            r <= n;
        end
    end

    assign link.cap_valid = r.valid;
    assign link.cap_word = r.word;
    assign link.enable = r.ctrl[dpllmt_pkg::CTRL_EN];
    assign link.dir = r.ctrl[dpllmt_pkg::CTRL_DIR];
    assign link.sec_sel = r.ctrl[dpllmt_pkg::CTRL_SEL_LSB +: 3];
    assign link.ticks_m1 = r.ticks[9:0];
    assign link.prof_len = r.plen[6:0];
    assign link.prof_we = r.prof_we;
    assign link.prof_addr = r.prof_addr;
    assign link.prof_gap = r.prof_gap;
    assign link.sync_req = r.sync_req;
    assign link.sync_ptr = r.sync_ptr;
    assign link.act_req = r.act_req;
    assign link.act_id = r.act_id;
    assign link.act_teeth = r.act_teeth;
    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.dat;
endmodule // dpllmt_ctrl
`default_nettype wire

//--- tb/dpllmt_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dpllmt_checker (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [5:0] cap_valid,
    input wire logic [5:0][48:0] cap_word,
    input wire logic enable,
    input wire logic sync_req,
    input wire logic act_req,
    input wire logic [23:0] ts0,
    input wire logic [3:0] micro_tick,
    input wire logic lock,
    input wire logic sync_ack,
    input wire logic sync_nak,
    input wire logic act_ack
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // ****************************************
    // Sync accepted since last enable
    // ****************************************
    logic synced_r;
    logic synced_nxt;
    always_comb begin
        synced_nxt = (synced_r | sync_ack) & enable;
    end
    always_ff @(posedge mclk) begin
        synced_r <= reset ? 1'b0 : synced_nxt;
    end
    property p_sync_answer;
        sync_req |=> sync_ack != sync_nak;
    endproperty
    a_sync_answer: assert property (p_sync_answer)
        else $error("sync request without single answer");
    property p_sync_cause;
        sync_ack || sync_nak |-> $past(sync_req);
    endproperty
    a_sync_cause: assert property (p_sync_cause)
        else $error("sync answer without request");
    property p_act_answer;
        act_req |=> act_ack ##1 !act_ack;
    endproperty
    a_act_answer: assert property (p_act_answer)
        else $error("action request not acknowledged once");
    property p_lock_off;
        !enable ##1 !enable |-> !lock;
    endproperty
    a_lock_off: assert property (p_lock_off)
        else $error("lock held while disabled");
    property p_catchup_off;
        !enable [*3] |-> micro_tick[1] == 1'b0 && micro_tick[3] == 1'b0;
    endproperty
    a_catchup_off: assert property (p_catchup_off)
        else $error("catch-up tick while disabled");
    property p_lock_rise;
        $rose(lock) |-> synced_r && $past(cap_valid[0]);
    endproperty
    a_lock_rise: assert property (p_lock_rise)
        else $error("lock rose without sync and primary edge");
    property p_ts0_step;
        !$past(reset) |-> ts0 == $past(ts0) + 24'h00_0001;
    endproperty
    a_ts0_step: assert property (p_ts0_step)
        else $error("time count did not step by one");
    property p_cap_stamp;
        cap_valid[0] |-> 24'(ts0 - cap_word[0][23:0]) < 24'h00_0008;
    endproperty
    a_cap_stamp: assert property (p_cap_stamp)
        else $error("capture stamp far from time count");
endmodule // dpllmt_checker
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic cs = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic [5:0] pin = 6'h00;
    logic lock_flag;
    logic [3:0] mt;
    logic [31:0] q;
    logic [23:0] tsq[$];
    logic [6:0] teeth;
    logic [1:0] id;
    int fails = 0;
    int num_checks = 0;
    int cyc_n = 0;
    int ptk = 0;
    int stk = 0;
    int tk = 10;
    int h;
    int angle;
    int tq;
    dpllmt_if link ();
    dpllmt_ctrl i_dpllmt_ctrl (.link(link.ctl), .mclk(mclk), .reset(reset),
        .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cap_pin(pin));
    dpllmt_core i_dpllmt_core (.link(link.dev), .mclk(mclk), .reset(reset),
        .first_lock_flag(lock_flag), .micro_tick(mt));
    dpllmt_checker i_dpllmt_checker (.mclk(mclk), .reset(reset),
        .cap_valid(link.cap_valid), .cap_word(link.cap_word),
        .enable(link.enable), .sync_req(link.sync_req),
        .act_req(link.act_req), .ts0(link.ts0), .micro_tick(link.micro_tick),
        .lock(link.lock), .sync_ack(link.sync_ack), .sync_nak(link.sync_nak),
        .act_ack(link.act_ack));
    initial begin
        forever #25 mclk = ~mclk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input int d);
        @(posedge mclk);
        cs <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        q = rdat;
        cs <= 1'b0;
    endtask
    task automatic toggle(input int n, input logic [5:0] m);
        repeat (n) @(posedge mclk);
        pin <= pin ^ m;
    endtask
    // Edge 0 of each turn closes the long interval of the missing teeth
    task automatic wheel(input int from, input int to);
        for (int i = from; i <= to; i++) begin
            toggle(i % 116 == 0 ? 5 * h : h, 6'h01);
        end
    endtask
    // Tick counts and capture stamps kept for the model
    always @(posedge mclk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 60000) begin
            fails++;
            conclude();
        end
        if (!reset) begin
            ptk = ptk + mt[0] + mt[1];
            stk = stk + mt[2] + mt[3];
            if (link.cap_valid[0] === 1'b1) begin
                tsq.push_back(link.cap_word[0][23:0]);
            end
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(99));
        h = 40 + $urandom % 16;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        wb(0, dpllmt_pkg::OFF_PLEN, 0);
        `CHK(q, 32'h0000_0074)
        wb(1, 8'h30, -1);
        wb(0, 8'h30, 0);
        `CHK(q, 32'h0000_0000)
        wb(1, dpllmt_pkg::OFF_TICKS, tk - 1);
        wb(0, dpllmt_pkg::OFF_TICKS, 0);
        `CHK(q[9:0], 10'(tk - 1))
        for (int i = 0; i < 116; i++) begin
            wb(1, dpllmt_pkg::OFF_PROF, i << 8 | i == 0);
        end
        wb(1, dpllmt_pkg::OFF_CTRL, 32'h0000_0031);
        for (int i = 0; i < 6; i++) toggle(h, 6'h09);
        repeat (3 * h) @(posedge mclk);
        angle = 5 * tk;
        `CHK(ptk, angle)
        `CHK(stk, angle)
        wb(0, dpllmt_pkg::OFF_ANGLE, 0);
        `CHK(q[23:0], 24'(angle))
        wb(0, dpllmt_pkg::OFF_TCNT, 0);
        `CHK(q[23:0], 24'(angle))
        wb(0, dpllmt_pkg::OFF_TIME, 0);
        tq = q[23:0];
        wb(0, dpllmt_pkg::OFF_TIME, 0);
        `CHK(q[23:0], 24'(tq + 3))
        teeth = 7'($urandom_range(1, 127));
        id = 2'($urandom);
        wb(1, dpllmt_pkg::OFF_ACT, {id, 1'b0, teeth});
        wb(0, dpllmt_pkg::OFF_ATIME, 0);
        `CHK(q[23:0], 24'(tsq[$] + (tsq[$] - tsq[$-1]) * teeth))
        wb(0, dpllmt_pkg::OFF_AANG, 0);
        `CHK(q[23:0], 24'(angle + teeth * tk))
        wb(0, dpllmt_pkg::OFF_STATUS, 0);
        `CHK(q[3], 1'b1)
        wb(1, dpllmt_pkg::OFF_CTRL, 32'h0000_0033);
        for (int i = 0; i < 4; i++) toggle(h, 6'h01);
        repeat (3 * h) @(posedge mclk);
        angle = angle - 4 * tk;
        wb(0, dpllmt_pkg::OFF_ANGLE, 0);
        `CHK(q[23:0], 24'(angle))
        wb(1, dpllmt_pkg::OFF_CTRL, 0);
        wb(1, dpllmt_pkg::OFF_STATUS, 32'h0000_000E);
        wb(1, dpllmt_pkg::OFF_CTRL, 1);
        wheel(1, 5);
        wb(1, dpllmt_pkg::OFF_SYNC, 0);
        wb(0, dpllmt_pkg::OFF_STATUS, 0);
        `CHK(q[2:0], 3'b100)
        wb(1, dpllmt_pkg::OFF_STATUS, 32'h0000_0006);
        wheel(6, 116);
        // Gap edge needs four cycles to reach the core's history
        repeat (4) @(posedge mclk);
        wb(1, dpllmt_pkg::OFF_SYNC, 0);
        wb(0, dpllmt_pkg::OFF_STATUS, 0);
        `CHK(q[2:0], 3'b010)
        wheel(117, 174);
        `CHK(lock_flag, 1'b0)
        wheel(175, 348);
        repeat (8) @(posedge mclk);
        `CHK(lock_flag, 1'b1)
        wb(0, dpllmt_pkg::OFF_STATUS, 0);
        `CHK(q[0], 1'b1)
        wb(1, dpllmt_pkg::OFF_CTRL, 0);
        repeat (3) @(posedge mclk);
        `CHK(lock_flag, 1'b0)
        conclude();
    end
endmodule // testbench
`default_nettype wire
